//--- rtl/apz_top.sv
// async_port_zero: full duplex serial channel with mode, status and holding buffers
// assumes cpu-side strobes are one-cycle pulses on clock_i; serial_in_pin is asynchronous
`timescale 1ns/10ps

// Overview of operation
// RULE_01: rates 300 bps to 1,250 kbps from a programmable divisor of the system clock.
// RULE_02: one byte after a start bit, transmit and receive run simultaneously.
// RULE_03: rx_error_irq pulses on OR of parity, framing and overrun errors.
// RULE_04: rx_done_irq pulses when received byte enters the receive holding buffer.
// RULE_05: tx_done_irq pulses when a whole frame finishes shifting out.
// RULE_06: mode bit selects 7 or 8 data bits for both directions.
// RULE_07: parity is odd, even, fixed zero or none by mode bits.
// RULE_08: transmitter appends one or two stop bits by mode bit.
// RULE_09: error flags set on error; reading the error status clears them.
// RULE_10: transmit status shows buffer-holds-data and shifter-busy flags.
// RULE_11: receiver checks parity per mode; mismatch sets parity error flag.
// RULE_12: receive shifter goes serial to parallel, loads buffer after stop bit.
// RULE_13: receive buffer is 8 bits; 7-bit characters load zero into MSB.
// RULE_14: buffer load only while reception enabled, at end of frame.
// RULE_15: writing the transmit holding buffer starts a transmission.
// RULE_16: byte moved into transmit shifter is shifted out on serial_out_pin.
// RULE_17: transmit frame gets start, optional parity and configured stop bits.
// RULE_18: shift registers have no software read or write path.
// RULE_19: enabling while input pin is low starts reception at once.
// RULE_20: low start bit, LSB first, high stop bits, line idles high.
// RULE_21: framing error on low first stop bit; overrun if unread buffer overwritten.
module apz_top
  import apz_pkg::*;
#(
  parameter int DIV_W = APZ_DIV_W  // width of oversample divisor
) (
  input  wire logic             clock_i,                  // 25 MHz system clock
  input  wire logic             srst_i,                   // sync reset, active high
  input  wire logic [7:0]       line_mode_wdata_i,        // new line_mode_register value
  input  wire logic             line_mode_we_i,           // write strobe for mode
  input  wire logic [DIV_W-1:0] baud_div_i,               // clocks per 1/16 bit, >=1
  input  wire logic [7:0]       tx_wdata_i,               // transmit_holding_buffer data
  input  wire logic             tx_we_i,                  // write strobe, transmit buffer
  input  wire logic             rx_rd_i,                  // read strobe, receive buffer
  input  wire logic             err_rd_i,                 // read strobe, error status
  input  wire logic             serial_in_pin_i,          // serial input pin
  output logic [7:0]            line_mode_register_o,     // mode register readback
  output logic [7:0]            receive_holding_buffer_o, // received character
  output logic [7:0]            receive_error_status_o,   // pe/fe/ove flags
  output logic [7:0]            transmit_progress_status_o, // tbf/tsf flags
  output logic                  tx_ready_o,               // transmit buffer can take a write
  output logic                  rx_error_irq_o,           // reception error pulse
  output logic                  rx_done_irq_o,            // reception completion pulse
  output logic                  tx_done_irq_o,            // transmission completion pulse
  output logic                  serial_out_pin_o          // serial output pin
);
  localparam int QW = $clog2(APZ_FIFO_DEPTH) + 1;

  typedef struct packed {
    logic [7:0]       mode;
    logic [2:0]       sync;
    logic             rx_line;
    logic [DIV_W-1:0] tick_cnt;
    apz_ph_e          rph;
    logic [3:0]       rsub;
    logic [2:0]       rbit;
    logic [7:0]       rshift;
    logic             rpar;
    logic [7:0]       rbuf;
    logic             rfull;
    logic [2:0]       err;
    apz_ph_e          tph;
    logic [3:0]       tsub;
    logic [2:0]       tbit;
    logic [7:0]       tshift;
    logic             tpar;
    logic             tstop2;
    logic             txd;
    logic             irq_err;
    logic             irq_rx;
    logic             irq_tx;
    logic             tbf;
    logic [QW-1:0]    qcnt;
    logic             room;
    logic             rwait_hi;
  } apz_top_s;

  apz_top_s    st;
  apz_top_s    next_st;
  logic        tick;
  logic        uce;
  logic        rxe;
  logic        txe;
  logic        len7;
  logic        two_stop;
  logic [1:0]  pmode;
  logic [2:0]  last_bit;
  logic        par_bit;
  logic [7:0]  rx_char;
  logic [2:0]  new_err;

  apz_fifo_if #(.WIDTH(8)) txq ();

  apz_fifo #(
    .WIDTH (8),
    .DEPTH (APZ_FIFO_DEPTH)
  ) u_txq (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .f       (txq)
  );

  assign uce      = st.mode[APZ_MODE_UCE];
  assign rxe      = st.mode[APZ_MODE_RXE];
  assign txe      = st.mode[APZ_MODE_TXE];
  assign len7     = ~st.mode[APZ_MODE_CL];  // [RULE_06]
  assign two_stop = st.mode[APZ_MODE_SL];
  assign pmode    = {st.mode[APZ_MODE_PS1], st.mode[APZ_MODE_PS0]};
  assign last_bit = len7 ? 3'h6 : 3'h7;
  assign tick     = (st.tick_cnt == '0);

  // [RULE_15] a write lands in the fifo; back-pressure shows on tx_ready_o
  assign txq.in_valid  = tx_we_i && uce && txe;
  assign txq.in_data   = tx_wdata_i;
  assign txq.out_ready = (st.tph == APZ_IDLE) && uce && txe;

  // [RULE_13] 7-bit characters leave the top bit zero
  assign rx_char = len7 ? {1'b0, st.rshift[7:1]} : st.rshift;

  always_comb begin
    next_st = st;
    next_st.irq_err = 1'b0;
    next_st.irq_rx  = 1'b0;
    next_st.irq_tx  = 1'b0;
    new_err         = 3'h0;
    par_bit         = 1'b0;

    if (line_mode_we_i) begin
      next_st.mode = line_mode_wdata_i;
    end
    // pin sampled through three stages; change taken when last two agree
    next_st.sync = {st.sync[1:0], serial_in_pin_i};
    if (st.sync[1] == st.sync[2]) begin
      next_st.rx_line = st.sync[2];
    end
    // [RULE_01] 16x oversample tick from the programmed divisor
    next_st.tick_cnt = tick ? baud_div_i - 1'b1 : st.tick_cnt - 1'b1;

    // receiver; [RULE_18] shifter reachable only through the buffer
    if (st.rx_line || !uce || !rxe) begin
      next_st.rwait_hi = 1'b0;
    end
    if (!uce || !rxe) begin
      next_st.rph = APZ_IDLE;
    end else if (tick) begin
      next_st.rsub = st.rsub + 4'h1;
      unique case (st.rph)
        APZ_IDLE: begin
          // [RULE_19] [RULE_20] a low line is a start bit, even right at enable
          // a low tail after a framing error must not re-arm a false start
          if (!st.rx_line && !st.rwait_hi) begin
            next_st.rph  = APZ_START;
            next_st.rsub = 4'h1;
          end
        end
        APZ_START: begin
          if (st.rsub == 4'h7) begin
            if (st.rx_line) begin
              next_st.rph = APZ_IDLE;  // glitch, not a start bit
            end else begin
              next_st.rph  = APZ_DATA;
              next_st.rsub = 4'h8;
              next_st.rbit = 3'h0;
              next_st.rpar = 1'b0;
            end
          end
        end
        APZ_DATA: begin
          if (st.rsub == 4'h7) begin
            // [RULE_12] [RULE_20] lsb first into the top, shifting down
            next_st.rshift = {st.rx_line, st.rshift[7:1]};
            next_st.rpar   = st.rpar ^ st.rx_line;
            next_st.rbit   = st.rbit + 3'h1;
            if (st.rbit == last_bit) begin
              next_st.rph = (pmode == APZ_PAR_NONE) ? APZ_STOP : APZ_PAR;
            end
          end
        end
        APZ_PAR: begin
          if (st.rsub == 4'h7) begin
            next_st.rpar = st.rpar ^ st.rx_line;
            next_st.rph  = APZ_STOP;
          end
        end
        APZ_STOP: begin
          if (st.rsub == 4'h7) begin
            next_st.rph = APZ_IDLE;
            // [RULE_11] total ones: odd mode wants 1, even 0; zero mode wants bit 0
            unique case (pmode)
              APZ_PAR_ODD:  new_err[APZ_ERR_PE] = ~st.rpar;
              APZ_PAR_EVEN: new_err[APZ_ERR_PE] = st.rpar;
              APZ_PAR_ZERO: new_err[APZ_ERR_PE] = st.rpar ^ ^rx_char;
              APZ_PAR_NONE: new_err[APZ_ERR_PE] = 1'b0;
            endcase
            new_err[APZ_ERR_FE]  = ~st.rx_line;  // [RULE_21]
            next_st.rwait_hi     = ~st.rx_line;
            new_err[APZ_ERR_OVE] = st.rfull && !rx_rd_i;  // [RULE_21]
            // [RULE_14] [RULE_04] load buffer at frame end while enabled
            next_st.rbuf   = rx_char;
            next_st.rfull  = 1'b1;
            next_st.irq_rx = 1'b1;
            // [RULE_03] one interrupt for any of the three errors
            next_st.irq_err = |new_err;
          end
        end
        default: next_st.rph = APZ_IDLE;
      endcase
    end
    if (rx_rd_i && !next_st.irq_rx) begin
      next_st.rfull = 1'b0;
    end
    // [RULE_09] read clears, but a same-cycle new error still sets
    next_st.err = (err_rd_i ? 3'h0 : st.err) | new_err;

    // transmitter
    if (!uce || !txe) begin
      next_st.tph = APZ_IDLE;
      next_st.txd = 1'b1;
    end else begin
      if (st.tph == APZ_IDLE) begin
        next_st.txd = 1'b1;
        if (txq.out_valid) begin
          // [RULE_16] buffer byte moves into the shifter
          next_st.tshift = txq.out_data;
          next_st.tph    = APZ_START;
          next_st.tsub   = 4'h0;
          next_st.tstop2 = 1'b0;
          next_st.txd    = 1'b0;  // [RULE_17] [RULE_20] start bit low
        end
      end else if (tick) begin
        next_st.tsub = st.tsub + 4'h1;
        if (st.tsub == 4'hF) begin
          unique case (st.tph)
            APZ_START: begin
              next_st.tph  = APZ_DATA;
              next_st.tbit = 3'h0;
              next_st.txd  = st.tshift[0];  // [RULE_20] lsb first
              next_st.tpar = st.tshift[0];
              next_st.tshift = {1'b0, st.tshift[7:1]};
            end
            APZ_DATA: begin
              next_st.tbit = st.tbit + 3'h1;
              if (st.tbit == last_bit) begin
                // [RULE_07] [RULE_17] parity slot or straight to stop
                unique case (pmode)
                  APZ_PAR_ODD:  par_bit = ~st.tpar;
                  APZ_PAR_EVEN: par_bit = st.tpar;
                  APZ_PAR_ZERO: par_bit = 1'b0;
                  APZ_PAR_NONE: par_bit = 1'b1;
                endcase
                next_st.tph = (pmode == APZ_PAR_NONE) ? APZ_STOP : APZ_PAR;
                next_st.txd = par_bit;
              end else begin
                next_st.txd    = st.tshift[0];
                next_st.tpar   = st.tpar ^ st.tshift[0];
                next_st.tshift = {1'b0, st.tshift[7:1]};
              end
            end
            APZ_PAR: begin
              next_st.tph = APZ_STOP;
              next_st.txd = 1'b1;
            end
            APZ_STOP: begin
              // [RULE_08] second stop bit when selected
              if (two_stop && !st.tstop2) begin
                next_st.tstop2 = 1'b1;
              end else begin
                next_st.tph    = APZ_IDLE;
                next_st.irq_tx = 1'b1;  // [RULE_05]
              end
              next_st.txd = 1'b1;
            end
            default: next_st.tph = APZ_IDLE;
          endcase
        end
      end
    end
    // shadow fill count keeps status and ready on flops, no dip on a pop
    next_st.qcnt = st.qcnt + QW'(txq.in_valid && txq.in_ready)
                 - QW'(txq.out_valid && txq.out_ready);
    next_st.tbf  = (next_st.qcnt != '0);
    next_st.room = (next_st.qcnt != QW'(APZ_FIFO_DEPTH));
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st          <= '0;
      st.mode     <= APZ_MODE_RST;
      st.sync     <= 3'h7;
      st.rx_line  <= 1'b1;
      st.txd      <= 1'b1;
      st.room     <= 1'b1;
      st.rph      <= APZ_IDLE;
      st.tph      <= APZ_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // [RULE_10] [RULE_02] status and outputs straight from flops
  assign line_mode_register_o       = st.mode;
  assign receive_holding_buffer_o   = st.rbuf;
  assign receive_error_status_o     = {5'h00, st.err};
  assign transmit_progress_status_o = {6'h00, st.tbf, st.tph != APZ_IDLE};
  assign tx_ready_o                 = st.room;
  assign rx_error_irq_o             = st.irq_err;
  assign rx_done_irq_o              = st.irq_rx;
  assign tx_done_irq_o              = st.irq_tx;
  assign serial_out_pin_o           = st.txd;

  sequence s_stop_done;
    (st.tph == APZ_STOP) && tick && (st.tsub == 4'hF) && (!two_stop || st.tstop2);
  endsequence
  property p_tx_done;
    @(posedge clock_i) disable iff (srst_i) s_stop_done and (uce && txe) |=> tx_done_irq_o;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("tx done missing"); // [RULE_05]
  property p_rx_done_load;
    @(posedge clock_i) disable iff (srst_i) rx_done_irq_o |-> st.rfull;
  endproperty
  a_rx_done_load: assert property (p_rx_done_load) else $error("rx done w/o load"); // [RULE_04]
  property p_err_irq;
    @(posedge clock_i) disable iff (srst_i) rx_error_irq_o |-> st.err != 3'h0;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("error irq without flag"); // [RULE_03]
  property p_msb_zero;
    @(posedge clock_i) disable iff (srst_i) rx_done_irq_o && len7 |-> !st.rbuf[7];
  endproperty
  a_msb_zero: assert property (p_msb_zero) else $error("7-bit msb set"); // [RULE_13]
  property p_idle_high;
    @(posedge clock_i) disable iff (srst_i) $past(st.tph) == APZ_IDLE && !$past(txq.out_valid)
      |-> serial_out_pin_o;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line not idle high"); // [RULE_20]
  property p_start_low;
    @(posedge clock_i) disable iff (srst_i) st.tph == APZ_START |-> !serial_out_pin_o;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit not low"); // [RULE_17]
  property p_rx_off;
    @(posedge clock_i) disable iff (srst_i) !$past(rxe) |-> !rx_done_irq_o;
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("load while disabled"); // [RULE_14]
  property p_set_wins;
    @(posedge clock_i) disable iff (srst_i)
      err_rd_i && (new_err != 3'h0) |=> receive_error_status_o[2:0] == $past(new_err);
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("read lost a new error"); // [RULE_09]
  property p_read_clear;
    @(posedge clock_i) disable iff (srst_i)
      err_rd_i && !next_st.irq_err |=> receive_error_status_o == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags not cleared"); // [RULE_09]
  property p_busy;
    @(posedge clock_i) disable iff (srst_i)
      txq.out_valid && txq.out_ready |=> transmit_progress_status_o[APZ_TPS_TSF];
  endproperty
  a_busy: assert property (p_busy) else $error("busy flag wrong"); // [RULE_10]
endmodule

//--- inc/apz_pkg.sv
// package for async_port_zero: mode field positions, reset values, timing constants
// assumes a single 25 MHz system clock; baud divisor supplied by the caller
package apz_pkg;
  localparam int          APZ_CLK_HZ        = 25_000_000;
  localparam int          APZ_MIN_BPS       = 300;
  localparam int          APZ_MAX_BPS       = 1_250_000;
  localparam int          APZ_OVS           = 16;
  // divisor of clock per oversample tick; longest tick is at the slowest rate
  localparam int          APZ_DIV_MAX       = APZ_CLK_HZ / (APZ_MIN_BPS * APZ_OVS);
  localparam int          APZ_DIV_MIN       = APZ_CLK_HZ / (APZ_MAX_BPS * APZ_OVS);
  localparam int          APZ_DIV_W         = 13;
  localparam logic [12:0] APZ_DIV_RST       = 13'h0001;
  // line_mode_register field positions
  localparam int          APZ_MODE_ISRM     = 0;
  localparam int          APZ_MODE_SL       = 1;
  localparam int          APZ_MODE_CL       = 2;
  localparam int          APZ_MODE_PS0      = 3;
  localparam int          APZ_MODE_PS1      = 4;
  localparam int          APZ_MODE_RXE      = 5;
  localparam int          APZ_MODE_TXE      = 6;
  localparam int          APZ_MODE_UCE      = 7;
  localparam logic [7:0]  APZ_MODE_RST      = 8'h01;
  // parity encoding of bits PS1:PS0
  localparam logic [1:0]  APZ_PAR_NONE      = 2'h0;
  localparam logic [1:0]  APZ_PAR_ZERO      = 2'h1;
  localparam logic [1:0]  APZ_PAR_ODD       = 2'h2;
  localparam logic [1:0]  APZ_PAR_EVEN      = 2'h3;
  // receive_error_status bit positions
  localparam int          APZ_ERR_OVE       = 0;
  localparam int          APZ_ERR_FE        = 1;
  localparam int          APZ_ERR_PE        = 2;
  // transmit_progress_status bit positions
  localparam int          APZ_TPS_TSF       = 0;
  localparam int          APZ_TPS_TBF       = 1;
  localparam int          APZ_FIFO_DEPTH    = 16;
  localparam int          APZ_SYNC_STAGES   = 3;

  typedef enum logic [2:0] {APZ_IDLE, APZ_START, APZ_DATA, APZ_PAR, APZ_STOP} apz_ph_e;
endpackage

//--- inc/apz_fifo_if.sv
// stream carrier between the top module and its transmit fifo
// assumes both ends share clock_i
`timescale 1ns/10ps
interface apz_fifo_if #(parameter int WIDTH = 8);
  logic             in_valid;
  logic             in_ready;
  logic [WIDTH-1:0] in_data;
  logic             out_valid;
  logic             out_ready;
  logic [WIDTH-1:0] out_data;
  modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
  modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface

//--- rtl/apz_fifo.sv
// synchronous fifo with valid/ready on both sides
// assumes single clock, synchronous active high reset
`timescale 1ns/10ps
module apz_fifo
  import apz_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = APZ_FIFO_DEPTH
) (
  input  wire logic clock_i,  // system clock
  input  wire logic srst_i,   // sync reset
  apz_fifo_if.fifo  f         // stream ports
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } apz_fifo_s;

  logic [WIDTH-1:0] mem [DEPTH];
  apz_fifo_s        st;
  apz_fifo_s        next_st;
  logic             push;
  logic             pop;

  assign f.in_ready  = (st.cnt != (AW+1)'(DEPTH));
  assign f.out_valid = (st.cnt != '0);
  assign f.out_data  = mem[st.rp];
  assign push        = f.in_valid && f.in_ready;
  assign pop         = f.out_valid && f.out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wp = st.wp + 1'b1;
    end
    if (pop) begin
      next_st.rp = st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
    if (push) begin
      mem[st.wp] <= f.in_data;
    end
  end

  property p_no_overflow;
    @(posedge clock_i) disable iff (srst_i) st.cnt <= (AW+1)'(DEPTH);
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("fifo overflow"); // [RULE_15]
endmodule

//--- test/apz_remote.sv
// remote serial device: sends frames on serial_in_pin, decodes serial_out_pin
// assumes the bench sets nbits, par, stops and bit_clks to match mode and divisor
`timescale 1ns/10ps
module apz_remote #(
  parameter int BIT = 16  // clocks per bit
) (
  input  wire logic clock_i,  // system clock
  input  wire logic line_i,   // from serial_out_pin
  output logic      line_o    // to serial_in_pin
);
  int         nbits    = 8;
  logic [1:0] par      = 2'h0;
  int         stops    = 1;
  logic [7:0] got_data = 8'h00;
  logic       got_par  = 1'b0;
  logic [1:0] got_stop = 2'h0;
  int         frames   = 0;
  int         bit_clks = BIT;

  initial line_o = 1'b1;  // idles high

  task automatic bits(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // low start, lsb first, parity, stop, then idle high
  task automatic send(input logic [7:0] d, input logic p, input logic stop_b);
    int i;
    line_o = 1'b0;
    bits(bit_clks);
    for (i = 0; i < nbits; i++) begin
      line_o = d[i];
      bits(bit_clks);
    end
    if (par != 2'h0) begin
      line_o = p;
      bits(bit_clks);
    end
    line_o = stop_b;
    bits(bit_clks);
    line_o = 1'b1;
    bits(2 * bit_clks);
  endtask

  // samples mid-bit, counted from the start edge
  initial begin
    int i;
    forever begin
      @(negedge line_i);
      repeat (bit_clks / 2) @(posedge clock_i);
      got_data = 8'h00;
      for (i = 0; i < nbits; i++) begin
        repeat (bit_clks) @(posedge clock_i);
        got_data[i] = line_i;
      end
      if (par != 2'h0) begin
        repeat (bit_clks) @(posedge clock_i);
        got_par = line_i;
      end
      got_stop = 2'h0;
      for (i = 0; i < stops; i++) begin
        repeat (bit_clks) @(posedge clock_i);
        got_stop[i] = line_i;
      end
      frames++;
    end
  end
endmodule

//--- test/apz_top_tb.sv
// bench for apz_top: frames against a remote model, mode and status ports
// assumes one bit lasts 16 clocks per unit of baud_div
`timescale 1ns/10ps
module apz_top_tb
  import apz_pkg::*;
;
  logic       clock_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [7:0] line_mode_wdata_i = 8'h00;
  logic       line_mode_we_i = 1'b0;
  logic [7:0] tx_wdata_i = 8'h00;
  logic       tx_we_i = 1'b0;
  logic       rx_rd_i = 1'b0;
  logic       err_rd_i = 1'b0;
  logic       serial_in_pin_i;
  logic [12:0] baud_div = 13'h0001;
  logic [7:0] mode_rb, rxb, err_st, tps;
  logic       tx_ready, err_irq, rxd_irq, txd_irq, serial_out;
  int         errors = 0;
  int         samples_checked = 0;
  int         n_rxd = 0;
  int         n_txd = 0;
  int         n_err = 0;

  initial forever #20 clock_i = ~clock_i;

  apz_top i_apz_top (
    .clock_i(clock_i), .srst_i(srst_i), .line_mode_wdata_i(line_mode_wdata_i),
    .line_mode_we_i(line_mode_we_i), .baud_div_i(baud_div), .tx_wdata_i(tx_wdata_i),
    .tx_we_i(tx_we_i), .rx_rd_i(rx_rd_i), .err_rd_i(err_rd_i),
    .serial_in_pin_i(serial_in_pin_i), .line_mode_register_o(mode_rb),
    .receive_holding_buffer_o(rxb), .receive_error_status_o(err_st),
    .transmit_progress_status_o(tps), .tx_ready_o(tx_ready), .rx_error_irq_o(err_irq),
    .rx_done_irq_o(rxd_irq), .tx_done_irq_o(txd_irq), .serial_out_pin_o(serial_out));

  apz_remote #(.BIT(16)) i_apz_remote (
    .clock_i(clock_i), .line_i(serial_out), .line_o(serial_in_pin_i));

  // irqs are one-cycle pulses, so counting them catches doubles
  always @(posedge clock_i) begin
    if (rxd_irq === 1'b1) n_rxd++;
    if (txd_irq === 1'b1) n_txd++;
    if (err_irq === 1'b1) n_err++;
  end

  task automatic finish_test;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic step;
    @(posedge clock_i);
    #1;
  endtask

  task automatic wait_cnt(ref int c, input int target, input int lim);
    int k;
    for (k = 0; k < lim && c < target; k++) step();
    if (c < target) begin
      errors++;
      $display("wrong value wait count expected %0d seen %0d", target, c);
      finish_test();
    end
  endtask

  function automatic logic exp_par(input logic [7:0] d, input logic [7:0] m);
    logic [7:0] v;
    v = m[2] ? d : {1'b0, d[6:0]};
    case (m[4:3])
      APZ_PAR_ODD:  return ~^v;
      APZ_PAR_EVEN: return ^v;
      default:      return 1'b0;
    endcase
  endfunction

  // mode only changes while the input line idles high
  task automatic set_mode(input logic [7:0] m);
    line_mode_wdata_i = m;
    line_mode_we_i = 1'b1;
    step();
    line_mode_we_i = 1'b0;
    i_apz_remote.nbits = m[2] ? 8 : 7;
    i_apz_remote.par = m[4:3];
    i_apz_remote.stops = m[1] ? 2 : 1;
    step();
    check("mode readback", m, mode_rb);
  endtask

  task automatic t_reset;
    check("mode reset", APZ_MODE_RST, mode_rb);
    check("error reset", 8'h00, err_st);
    check("tx status reset", 8'h00, tps);
    check("idle pin", 8'h01, {7'h00, serial_out});
  endtask

  // transmit and receive at once, one frame each way
  task automatic t_duplex(input logic [7:0] m, input logic [7:0] dt, input logic [7:0] dr);
    int t0, r0;
    logic [7:0] v;
    set_mode(m);
    t0 = n_txd;
    r0 = n_rxd;
    v = m[2] ? 8'hFF : 8'h7F;
    fork
      i_apz_remote.send(dr, exp_par(dr, m), 1'b1);
      begin
        tx_wdata_i = dt;
        tx_we_i = 1'b1;
        step();
        tx_we_i = 1'b0;
        repeat (3) step();
        check("shifter busy", 8'h01, tps & 8'h01);
      end
    join
    wait_cnt(n_txd, t0 + 1, 400);
    wait_cnt(n_rxd, r0 + 1, 400);
    check("tx data", dt & v, i_apz_remote.got_data);
    if (m[4:3] != APZ_PAR_NONE) begin
      check("tx parity", {7'h00, exp_par(dt, m)}, {7'h00, i_apz_remote.got_par});
    end
    check("tx stop", m[1] ? 8'h03 : 8'h01, {6'h00, i_apz_remote.got_stop});
    check("rx data", dr & v, rxb);
    check("rx clean", 8'h00, err_st);
    repeat (2) step();
    check("tx done count", 8'h01, 8'(n_txd - t0));
    check("rx done count", 8'h01, 8'(n_rxd - r0));
    check("tx idle status", 8'h00, tps);
    rx_rd_i = 1'b1;
    step();
    rx_rd_i = 1'b0;
  endtask

  task automatic t_rx_err(input logic [7:0] m, input logic badp, input logic stop_b,
                          input int cnt, input logic [7:0] flags);
    int e0;
    set_mode(m);
    e0 = n_err;
    repeat (cnt) i_apz_remote.send(8'h5A, exp_par(8'h5A, m) ^ badp, stop_b);
    wait_cnt(n_err, e0 + 1, 100);
    check("error flags", flags, err_st);
    check("error irq count", 8'h01, 8'(n_err - e0));
    err_rd_i = 1'b1;
    rx_rd_i = 1'b1;
    step();
    err_rd_i = 1'b0;
    rx_rd_i = 1'b0;
    repeat (2) step();
    check("flags cleared", 8'h00, err_st);
  endtask

  task automatic t_rx_off;
    int r0;
    set_mode(8'hC4);
    r0 = n_rxd;
    i_apz_remote.send(8'h81, 1'b0, 1'b1);
    repeat (20) step();
    check("rx disabled", 8'h00, 8'(n_rxd - r0));
  endtask

  // fill the 16-word buffer until it refuses, then let it drain
  task automatic t_fifo;
    int n, t0;
    t0 = n_txd;
    n = 0;
    while (n < 20 && tx_ready === 1'b1) begin
      tx_wdata_i = 8'(n);
      tx_we_i = 1'b1;
      n++;
      step();
    end
    tx_wdata_i = 8'hEE; // one write while full must be dropped
    step();
    tx_we_i = 1'b0;
    check("fifo refuses", 8'h01, {7'h00, n >= 16 && n <= 17});
    check("buffer holds", 8'h02, tps & 8'h02);
    wait_cnt(n_txd, t0 + n, n * 200 + 50);
    repeat (2) step();
    check("drained", 8'h00, tps);
    check("last byte", 8'(n - 1), i_apz_remote.got_data);
  endtask

  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    srst_i = 1'b0;
    t_reset();
    t_duplex(8'hE4, 8'hA5, 8'h3C);
    t_duplex(8'hEA, 8'h96, 8'hC3);
    t_duplex(8'hF6, 8'h01, 8'hFE);
    t_duplex(8'hF8, 8'hFF, 8'h55);
    t_rx_err(8'hF4, 1'b1, 1'b1, 1, 8'h04);
    t_rx_err(8'hE4, 1'b0, 1'b0, 1, 8'h02);
    t_rx_err(8'hE4, 1'b0, 1'b1, 2, 8'h01);
    t_rx_off();
    t_fifo();
    baud_div = 13'h0002;
    i_apz_remote.bit_clks = 32;
    t_duplex(8'hE4, 8'h5C, 8'hA3);
    finish_test();
  end
endmodule
